/* common/tvd_pkg.sv */
// Constants, register map and mode codes of the output voter and diagnostics block
package tvd_pkg;

  // ----------------------------------------------------------------
  // Geometry
  // ----------------------------------------------------------------
  localparam int NPTS = 32;
  localparam int NCH = 3;
  localparam int NSUP = 4;
  localparam int CNT_W = 20;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [5:0] OFS_CTRL = 6'h00;
  localparam logic [5:0] OFS_STATUS = 6'h04;
  localparam logic [5:0] OFS_DIAG_FAULT = 6'h08;
  localparam logic [5:0] OFS_VOTED = 6'h0C;
  localparam logic [5:0] OFS_LOOPBACK = 6'h10;
  localparam logic [5:0] OFS_SUP_BASE = 6'h14;

  // Supervised fault kinds, one register each from OFS_SUP_BASE upward
  localparam int SUP_PWR_LOST = 0;
  localparam int SUP_OPEN_LOAD = 1;
  localparam int SUP_SHORT_ON = 2;
  localparam int SUP_SHORT_OFF = 3;

  // ----------------------------------------------------------------
  // Control and status fields
  // ----------------------------------------------------------------
  localparam int CTRL_ACTIVE_BIT = 0;
  localparam int CTRL_DIAG_EN_BIT = 1;
  localparam int CTRL_MODE_LSB = 4;
  localparam int CTRL_MODE_W = 3;
  localparam logic [31:0] CTRL_RESET = 32'h00000002;

  localparam int STAT_FAULT_BIT = 0;
  localparam int STAT_GLITCH_BIT = 1;
  localparam int STAT_HALT_BIT = 2;
  localparam int STAT_LOAD_LOST_BIT = 3;
  localparam int STAT_CH_LSB = 4;
  localparam int STAT_PT_LSB = 8;

  typedef enum logic [2:0] {
    MODE_DC_QUAD = 3'h0,
    MODE_AC_QUAD = 3'h1,
    MODE_DUAL = 3'h2,
    MODE_RELAY = 3'h3,
    MODE_SUPERVISED = 3'h4
  } tvd_mode_t;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam longint CLK_HZ = 10_000_000;
  localparam longint DC_GLITCH_TYP_US = 500;
  localparam longint DC_GLITCH_MAX_US = 2000;
  localparam longint AC_LINE_HZ_MAX = 63;
  localparam longint STEP_GAP_US = 1000;
  localparam longint SETTLE_US = 1000;

  localparam int GLITCH_CYC = int'((DC_GLITCH_TYP_US * CLK_HZ) / 1_000_000);
  localparam int GLITCH_MAX_CYC = int'((DC_GLITCH_MAX_US * CLK_HZ) / 1_000_000);
  localparam int AC_HALF_CYC = int'(CLK_HZ / (2 * AC_LINE_HZ_MAX));
  localparam int GAP_CYC = int'((STEP_GAP_US * CLK_HZ + 999_999) / 1_000_000);
  localparam int SETTLE_CYC = int'((SETTLE_US * CLK_HZ + 999_999) / 1_000_000);

endpackage

/* common/tvd_vote_if.sv */
// Carrier between the diagnostic core and the point voter array
`timescale 1ns/1ps
interface tvd_vote_if;
  logic [tvd_pkg::NCH-1:0][tvd_pkg::NPTS-1:0] cmd;
  logic [tvd_pkg::NPTS-1:0] inv_pt;
  logic [tvd_pkg::NCH-1:0] inv_ch;
  logic [1:0] inv_sw;
  logic [tvd_pkg::NPTS-1:0] vote1;
  logic [tvd_pkg::NPTS-1:0] vote2;
  logic [tvd_pkg::NPTS-1:0] vote_ref;

  modport core (
    output cmd,
    output inv_pt,
    output inv_ch,
    output inv_sw,
    input vote1,
    input vote2,
    input vote_ref
  );

  modport voter (
    input cmd,
    input inv_pt,
    input inv_ch,
    input inv_sw,
    output vote1,
    output vote2,
    output vote_ref
  );
endinterface

/* rtl/tvd_voter.sv */
// Two-out-of-three voter for every point and each of its two switches
`timescale 1ns/1ps
module tvd_voter (
  tvd_vote_if.voter vif
);
  import tvd_pkg::*;

  wire logic [NPTS-1:0] v1;
  wire logic [NPTS-1:0] v2;
  wire logic [NPTS-1:0] vr;

  genvar p;
  genvar c;
  generate
    for (p = 0; p < NPTS; p++) begin : g_pt
      wire logic [NCH-1:0] d1;
      wire logic [NCH-1:0] d2;
      wire logic [NCH-1:0] dr;
      for (c = 0; c < NCH; c++) begin : g_ch
        // Diagnostic inversion hits one driver, on one switch in the dual variant and on both switches otherwise
        assign dr[c] = vif.cmd[c][p];
        assign d1[c] = dr[c] ^ (vif.inv_pt[p] & vif.inv_ch[c] & vif.inv_sw[0]);
        assign d2[c] = dr[c] ^ (vif.inv_pt[p] & vif.inv_ch[c] & vif.inv_sw[1]);
      end
      assign v1[p] = (d1[0] & d1[1]) | (d1[1] & d1[2]) | (d1[0] & d1[2]); // R01 R02
      assign v2[p] = (d2[0] & d2[1]) | (d2[1] & d2[2]) | (d2[0] & d2[2]); // R02
      assign vr[p] = (dr[0] & dr[1]) | (dr[1] & dr[2]) | (dr[0] & dr[2]); // R01
    end
  endgenerate

  assign vif.vote1 = v1;
  assign vif.vote2 = v2;
  assign vif.vote_ref = vr;
endmodule

/* rtl/tvd_top.sv */
// Triplicated output voter with output voter diagnostic and field supervision
//
// Added by the designer: the Avalon-MM register port and the register addresses.
`timescale 1ns/1ps
// What the document requires
// R01 - A point is energized only when at least two of three channel drivers command it.
// R02 - Dual variant votes two-of-three separately on each of the two switches.
// R03 - Each channel loads its own output table independently of the others.
// R04 - Output voter diagnostic runs on every point; module type selects its variant.
// R05 - Diagnostic briefly inverts one driver at a time, stepping through all drivers.
// R06 - Loopback value is read during the diagnostic to decide on a latent fault.
// R07 - DC glitch under 2 ms, about 500 us; coverage kept with static commands.
// R08 - AC faulty switch flips the output no longer than half a line cycle.
// R09 - AC module stops further diagnostic iterations once a fault is found.
// R10 - Software can disable the diagnostic for loads intolerant of any transition.
// R11 - With diagnostic disabled, the controller cycles every point on and off itself.
// R12 - Relay variant votes three channel signal sets and drives 32 relays.
// R13 - Relay variant checks each relay through its loopback, load present or not.
// R14 - Supervised variant detects power loss, open load, short on, shorted load off.
// R15 - Supervised variant annunciates any loss of field load.
// R16 - Controller changes a point no faster than once per 100 ms plus a scan.
// R17 - AC points are toggled by the controller at least every three months.
// R18 - One indicator per point plus pass, fault and active module indicators.
// R19 - A field alarm indicator shows load or fuse faults.
// R20 - DC glitch at most 2 ms, and glitching stops when the diagnostic is disabled.
// R21 - Diagnostic faults latch per point and are reported until software clears them.
module tvd_top #(
  parameter int GLITCH_LEN = tvd_pkg::GLITCH_CYC,
  parameter int AC_HALF_LEN = tvd_pkg::AC_HALF_CYC,
  parameter int GAP_LEN = tvd_pkg::GAP_CYC,
  parameter int SETTLE_LEN = tvd_pkg::SETTLE_CYC
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic [tvd_pkg::NCH-1:0] tbl_load,
  input wire logic [tvd_pkg::NCH-1:0][tvd_pkg::NPTS-1:0] tbl_data,
  input wire logic [tvd_pkg::NPTS-1:0] loopback,
  input wire logic [tvd_pkg::NPTS-1:0] field_pwr_ok,
  input wire logic [tvd_pkg::NPTS-1:0] sense_volt,
  input wire logic [tvd_pkg::NPTS-1:0] sense_curr,
  output logic [tvd_pkg::NPTS-1:0] load_sw1,
  output logic [tvd_pkg::NPTS-1:0] load_sw2,
  output logic [tvd_pkg::NPTS-1:0] point_led,
  output logic pass_led,
  output logic fault_led,
  output logic active_led,
  output logic field_alarm_led,
  output logic load_lost,
  output logic [tvd_pkg::NPTS-1:0] fault_report
);
  import tvd_pkg::*;

  localparam logic [CNT_W-1:0] GLITCH_LIM = CNT_W'(GLITCH_LEN - 1);
  localparam logic [CNT_W-1:0] AC_LIM =
    CNT_W'(((AC_HALF_LEN < GLITCH_LEN) ? AC_HALF_LEN : GLITCH_LEN) - 1);
  localparam logic [CNT_W-1:0] GAP_LIM = CNT_W'(GAP_LEN - 1);
  localparam logic [CNT_W-1:0] SETTLE_LIM = CNT_W'(SETTLE_LEN - 1);
  localparam logic [1:0] LAST_CH = 2'(NCH - 1);

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_GAP = 4'b0010,
    ST_GLITCH = 4'b0100,
    ST_HALT = 4'b1000
  } tvd_state_t;

  tvd_vote_if vif ();

  tvd_voter u_voter (
    .vif(vif.voter)
  );

  // ----------------------------------------------------------------
  // Register bus slave
  // ----------------------------------------------------------------
  logic wait_r;
  logic [31:0] rdata_r;
  logic [31:0] ctrl_r;
  logic [NPTS-1:0] diag_flt_r;
  logic [NPTS-1:0] sup_flt_r [NSUP];

  wire logic req = avs_read | avs_write;
  wire logic ack = req & wait_r;
  wire logic wr_hit = avs_write & ~wait_r;
  wire logic [31:0] wmask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                             {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
  wire logic [31:0] wbits = avs_writedata & wmask;
  wire logic sel_ctrl = avs_address == OFS_CTRL;
  wire logic sel_stat = avs_address == OFS_STATUS;
  wire logic sel_diag = avs_address == OFS_DIAG_FAULT;
  wire logic sel_vote = avs_address == OFS_VOTED;
  wire logic sel_lb = avs_address == OFS_LOOPBACK;
  wire logic [NSUP-1:0] sel_sup;
  wire logic [31:0] sup_rd [NSUP+1];

  genvar k;
  generate
    for (k = 0; k < NSUP; k++) begin : g_sel
      assign sel_sup[k] = avs_address == 6'(OFS_SUP_BASE + 6'(4 * k));
      assign sup_rd[k + 1] = sup_rd[k] | ({32{sel_sup[k]}} & sup_flt_r[k]);
    end
  endgenerate
  assign sup_rd[0] = 32'h00000000;

  wire logic [31:0] ctrl_nxt = (ctrl_r & ~wmask) | wbits;
  wire tvd_mode_t mode = tvd_mode_t'(ctrl_r[CTRL_MODE_LSB +: CTRL_MODE_W]);
  wire logic active = ctrl_r[CTRL_ACTIVE_BIT];
  wire logic diag_en = ctrl_r[CTRL_DIAG_EN_BIT];
  wire logic is_ac = mode == MODE_AC_QUAD;
  wire logic is_dual = mode == MODE_DUAL;
  wire logic is_relay = mode == MODE_RELAY;
  wire logic is_sup = mode == MODE_SUPERVISED;

  // ----------------------------------------------------------------
  // Channel output tables
  // ----------------------------------------------------------------
  logic [NCH-1:0][NPTS-1:0] tbl_r;

  genvar c;
  generate
    for (c = 0; c < NCH; c++) begin : g_tbl
      always_ff @(posedge clk) begin
        if (rst) begin
          tbl_r[c] <= '0;
        end else if (tbl_load[c]) begin
          tbl_r[c] <= tbl_data[c]; // R03
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Diagnostic sequencer
  // ----------------------------------------------------------------
  tvd_state_t st_r;
  tvd_state_t st_nxt;
  logic [4:0] pt_r;
  logic [1:0] ch_r;
  logic sw_r;
  logic [CNT_W-1:0] cnt_r;

  // Relay modules never glitch; AC and dual run their own variants, every other type the DC one
  wire logic diag_run = active & diag_en & ~is_relay; // R04 R10 R20
  wire logic in_glitch = st_r == ST_GLITCH;
  wire logic [CNT_W-1:0] glitch_lim = is_ac ? AC_LIM : GLITCH_LIM; // R07 R08
  wire logic cnt_done = in_glitch ? (cnt_r == glitch_lim) : (cnt_r == GAP_LIM);
  wire logic mismatch = loopback[pt_r] != vif.vote_ref[pt_r]; // R06
  wire logic ac_trip = in_glitch & is_ac & mismatch; // R08
  wire logic glitch_end = in_glitch & cnt_done;
  wire logic diag_hit = ac_trip | (glitch_end & mismatch); // R06
  wire logic sw_wrap = ~is_dual | sw_r;
  wire logic ch_wrap = sw_wrap & (ch_r == LAST_CH);

  always_comb begin
    st_nxt = st_r;
    unique case (st_r)
      ST_IDLE: begin
        if (diag_run) begin
          st_nxt = ST_GAP;
        end
      end
      ST_GAP: begin
        if (!diag_run) begin
          st_nxt = ST_IDLE;
        end else if (cnt_done) begin
          st_nxt = ST_GLITCH; // R07
        end
      end
      ST_GLITCH: begin
        if (!diag_run) begin
          st_nxt = ST_IDLE; // R20
        end else if (ac_trip || (glitch_end && is_ac && mismatch)) begin
          st_nxt = ST_HALT; // R09
        end else if (glitch_end) begin
          st_nxt = ST_GAP;
        end
      end
      ST_HALT: begin
        if (!diag_run || diag_flt_r == '0) begin
          st_nxt = ST_IDLE;
        end
      end
      default: st_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_r <= ST_IDLE;
      cnt_r <= '0;
      pt_r <= 5'h00;
      ch_r <= 2'h0;
      sw_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      cnt_r <= (st_nxt != st_r || cnt_done) ? '0 : cnt_r + 1'b1;
      if (glitch_end && st_nxt == ST_GAP) begin
        // Step switch, then driver, then point, so all drivers get their turn
        sw_r <= is_dual & ~sw_r; // R05
        ch_r <= ch_wrap ? 2'h0 : (sw_wrap ? ch_r + 2'h1 : ch_r); // R05
        pt_r <= ch_wrap ? pt_r + 5'h01 : pt_r; // R04 R07
      end
    end
  end

  assign vif.cmd = tbl_r;
  assign vif.inv_pt = in_glitch ? (32'h00000001 << pt_r) : '0; // R05
  assign vif.inv_ch = 3'(3'h1 << ch_r); // R05
  assign vif.inv_sw = is_dual ? (sw_r ? 2'b10 : 2'b01) : 2'b11; // R02

  // ----------------------------------------------------------------
  // Load drive and loopback supervision
  // ----------------------------------------------------------------
  logic [CNT_W-1:0] stl_r;
  logic [NPTS-1:0] sw1_r;
  logic [NPTS-1:0] sw2_r;

  wire logic settled = (stl_r == SETTLE_LIM) & ~in_glitch;
  wire logic [NPTS-1:0] relay_set = (is_relay & settled) ? (loopback ^ sw1_r) : '0; // R13
  wire logic [NPTS-1:0] pt_mask = 32'h00000001 << pt_r;
  wire logic [NPTS-1:0] diag_set = (diag_hit ? pt_mask : '0) | relay_set;
  wire logic [NPTS-1:0] diag_clr = (wr_hit && sel_diag) ? wbits : '0;
  wire logic [NPTS-1:0] diag_nxt = (diag_flt_r & ~diag_clr) | diag_set; // R21
  wire logic sup_on = is_sup & settled;
  wire logic [NPTS-1:0] sup_set [NSUP];

  assign sup_set[SUP_PWR_LOST] = sup_on ? ~field_pwr_ok : '0; // R14
  assign sup_set[SUP_OPEN_LOAD] = sup_on ? (sw1_r & field_pwr_ok & ~sense_curr) : '0; // R14
  assign sup_set[SUP_SHORT_ON] = sup_on ? (~sw1_r & sense_volt) : '0; // R14
  assign sup_set[SUP_SHORT_OFF] = sup_on ? (~sw1_r & sense_curr) : '0; // R14

  generate
    for (k = 0; k < NSUP; k++) begin : g_sup
      wire logic [NPTS-1:0] clr = (wr_hit && sel_sup[k]) ? wbits : '0;
      always_ff @(posedge clk) begin
        if (rst) begin
          sup_flt_r[k] <= '0;
        end else begin
          sup_flt_r[k] <= (sup_flt_r[k] & ~clr) | sup_set[k];
        end
      end
    end
  endgenerate

  wire logic any_diag = |diag_nxt;
  wire logic [NPTS-1:0] sup_clr_open = (wr_hit && sel_sup[SUP_OPEN_LOAD]) ? wbits : '0;
  wire logic open_any = |((sup_flt_r[SUP_OPEN_LOAD] & ~sup_clr_open) | sup_set[SUP_OPEN_LOAD]);
  wire logic field_any = open_any | (|sup_flt_r[SUP_PWR_LOST]) | (|sup_flt_r[SUP_SHORT_ON])
                         | (|sup_flt_r[SUP_SHORT_OFF]) | (|sup_set[SUP_PWR_LOST]);

  always_ff @(posedge clk) begin
    if (rst) begin
      stl_r <= '0;
      sw1_r <= '0;
      sw2_r <= '0;
      diag_flt_r <= '0;
    end else begin
      sw1_r <= active ? vif.vote1 : '0; // R01 R12
      sw2_r <= active ? vif.vote2 : '0; // R02
      stl_r <= (vif.vote1 != sw1_r || in_glitch) ? '0 : (settled ? stl_r : stl_r + 1'b1);
      diag_flt_r <= diag_nxt; // R21
    end
  end

  // ----------------------------------------------------------------
  // Indicators and fault report
  // ----------------------------------------------------------------
  logic [NPTS-1:0] led_r;
  logic pass_r;
  logic fault_r;
  logic act_r;
  logic alarm_r;
  logic lost_r;

  always_ff @(posedge clk) begin
    if (rst) begin
      led_r <= '0;
      pass_r <= 1'b0;
      fault_r <= 1'b0;
      act_r <= 1'b0;
      alarm_r <= 1'b0;
      lost_r <= 1'b0;
    end else begin
      led_r <= active ? vif.vote_ref : '0; // R18
      pass_r <= active & ~any_diag; // R18
      fault_r <= any_diag; // R18 R21
      act_r <= active; // R18
      alarm_r <= field_any; // R19
      lost_r <= open_any; // R15
    end
  end

  wire logic [31:0] status_val = {19'h00000, pt_r, 2'h0, ch_r, lost_r,
                                  st_r == ST_HALT, in_glitch, |diag_flt_r};
  wire logic [31:0] rd_val = ({32{sel_ctrl}} & ctrl_r) | ({32{sel_stat}} & status_val)
                             | ({32{sel_diag}} & diag_flt_r) | ({32{sel_vote}} & sw1_r)
                             | ({32{sel_lb}} & loopback) | sup_rd[NSUP];

  always_ff @(posedge clk) begin
    if (rst) begin
      wait_r <= 1'b1;
      rdata_r <= 32'h00000000;
      ctrl_r <= CTRL_RESET;
    end else begin
      wait_r <= ~ack;
      rdata_r <= rd_val;
      if (wr_hit && sel_ctrl) begin
        ctrl_r <= ctrl_nxt; // R10
      end
    end
  end

  assign avs_readdata = rdata_r;
  assign avs_waitrequest = wait_r;
  assign load_sw1 = sw1_r;
  assign load_sw2 = sw2_r;
  assign point_led = led_r;
  assign pass_led = pass_r;
  assign fault_led = fault_r;
  assign active_led = act_r;
  assign field_alarm_led = alarm_r;
  assign load_lost = lost_r;
  assign fault_report = diag_flt_r; // R21
endmodule

/* test/tvd_top_monitor.sv */
// Checker of the voter outputs against commands and register writes
`timescale 1ns/1ps
module tvd_top_monitor #(
  parameter int GLITCH_LEN = tvd_pkg::GLITCH_CYC,
  parameter int AC_HALF_LEN = tvd_pkg::AC_HALF_CYC
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [5:0] avs_address,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic avs_waitrequest,
  input wire logic [tvd_pkg::NCH-1:0] tbl_load,
  input wire logic [tvd_pkg::NCH-1:0][tvd_pkg::NPTS-1:0] tbl_data,
  input wire logic [tvd_pkg::NPTS-1:0] load_sw1,
  input wire logic [tvd_pkg::NPTS-1:0] load_sw2,
  input wire logic [tvd_pkg::NPTS-1:0] point_led,
  input wire logic [tvd_pkg::NPTS-1:0] fault_report
);
  import tvd_pkg::*;
  localparam int AC_LIM = (AC_HALF_LEN < GLITCH_LEN) ? AC_HALF_LEN : GLITCH_LEN;
  logic [6:0] ctrl_r;
  logic [15:0] run_r;
  logic [NCH-1:0][NPTS-1:0] tbl_r;
  logic [NPTS-1:0] vote_w;
  logic ack_w, ac_w, clr_w;
  // ----------------------------------------------------------------
  // Shadow of control and tables, glitch length counter
  // ----------------------------------------------------------------
  assign ack_w = avs_write && !avs_waitrequest;
  assign ac_w = ctrl_r[6:4] == MODE_AC_QUAD;
  assign clr_w = ack_w && avs_address == OFS_DIAG_FAULT;
  assign vote_w = (tbl_r[0] & tbl_r[1]) | (tbl_r[1] & tbl_r[2]) | (tbl_r[0] & tbl_r[2]);
  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl_r <= CTRL_RESET[6:0];
    end else if (ack_w && avs_address == OFS_CTRL && avs_byteenable[0]) begin
      ctrl_r <= avs_writedata[6:0];
    end
  end
  always_ff @(posedge clk) begin
    if (rst || load_sw1 == point_led) begin
      run_r <= '0;
    end else if (run_r != 16'hFFFF) begin
      run_r <= run_r + 16'h0001;
    end
  end
  always_ff @(posedge clk) begin
    for (int c = 0; c < NCH; c++) begin
      if (tbl_load[c]) begin
        tbl_r[c] <= tbl_data[c];
      end
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  property p_glitch_dc;
    !ac_w |-> run_r <= 16'(GLITCH_LEN);
  endproperty
  a_glitch_dc: assert property (p_glitch_dc) else $error("glitch too long");
  property p_glitch_ac;
    ac_w |-> run_r <= 16'(AC_LIM);
  endproperty
  a_glitch_ac: assert property (p_glitch_ac) else $error("ac glitch too long");
  property p_diag_off;
    !ctrl_r[1] [*3] |-> load_sw1 == point_led;
  endproperty
  a_diag_off: assert property (p_diag_off) else $error("glitch while disabled");
  property p_sw2_same;
    (ctrl_r[6:4] != MODE_DUAL) [*3] |-> load_sw2 == load_sw1;
  endproperty
  a_sw2_same: assert property (p_sw2_same) else $error("switches differ");
  property p_relay_quiet;
    (ctrl_r[6:4] == MODE_RELAY) [*3] |-> load_sw1 == point_led;
  endproperty
  a_relay_quiet: assert property (p_relay_quiet) else $error("relay disturbed");
  property p_ac_halt;
    (ac_w && |fault_report) [*3] |-> load_sw1 == point_led;
  endproperty
  a_ac_halt: assert property (p_ac_halt) else $error("ac diag not halted");
  property p_fault_hold;
    |($past(fault_report) & ~fault_report) |-> $past(clr_w) || !ctrl_r[0];
  endproperty
  a_fault_hold: assert property (p_fault_hold) else $error("fault dropped");
  property p_vote;
    ctrl_r[0] [*3] |-> point_led == $past(vote_w);
  endproperty
  a_vote: assert property (p_vote) else $error("vote wrong");
endmodule
bind tvd_top tvd_top_monitor #(.GLITCH_LEN(GLITCH_LEN), .AC_HALF_LEN(AC_HALF_LEN)) mon_u (
  .clk(clk), .rst(rst), .avs_address(avs_address), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_waitrequest(avs_waitrequest), .tbl_load(tbl_load), .tbl_data(tbl_data),
  .load_sw1(load_sw1), .load_sw2(load_sw2), .point_led(point_led),
  .fault_report(fault_report));

/* test/tvd_proc_model.sv */
// Model of the three main processors and of the field wiring at the outputs
`timescale 1ns/1ps
module tvd_proc_model (
  input wire logic clk,
  input wire logic [tvd_pkg::NPTS-1:0] load_sw1,
  input wire logic [tvd_pkg::NPTS-1:0] point_led,
  output logic [tvd_pkg::NCH-1:0] tbl_load,
  output logic [tvd_pkg::NCH-1:0][tvd_pkg::NPTS-1:0] tbl_data,
  output logic [tvd_pkg::NPTS-1:0] loopback,
  output logic [tvd_pkg::NPTS-1:0] field_pwr_ok,
  output logic [tvd_pkg::NPTS-1:0] sense_volt,
  output logic [tvd_pkg::NPTS-1:0] sense_curr
);
  import tvd_pkg::*;
  logic [NPTS-1:0] lb_flip, no_pwr, open_ld, shrt_on, shrt_off;
  initial begin
    tbl_load = '0;
    tbl_data = '0;
    {lb_flip, no_pwr, open_ld, shrt_on, shrt_off} = '0;
  end
  // ----------------------------------------------------------------
  // Field: healthy voter loops back the undisturbed vote
  // ----------------------------------------------------------------
  assign loopback = point_led ^ lb_flip;
  assign field_pwr_ok = ~no_pwr;
  assign sense_volt = (load_sw1 & ~no_pwr) | shrt_on;
  assign sense_curr = (load_sw1 & ~no_pwr & ~open_ld) | shrt_off;
  // Each processor hands over its table on an edge of its own
  task send(input logic [NCH-1:0][NPTS-1:0] t);
    for (int c = 0; c < NCH; c++) begin
      @(posedge clk);
      tbl_data[c] <= t[c];
      tbl_load <= NCH'(1 << c);
    end
    @(posedge clk);
    tbl_load <= '0;
  endtask
endmodule

/* test/tvd_top_tb.sv */
// Self-checking bench of the output voter and diagnostics block
`timescale 1ns/1ps
module tvd_top_tb;
  import tvd_pkg::*;
  localparam logic [31:0] ONES = 32'hFFFFFFFF;
  localparam logic [31:0] SUP_EXP [NSUP] = '{32'h1, 32'h2, 32'h10000, 32'h20000};
  logic clk, rst, avs_read, avs_write, avs_waitrequest, pass_led, fault_led, active_led;
  logic field_alarm_led, load_lost;
  logic [5:0] avs_address;
  logic [3:0] avs_byteenable;
  logic [31:0] avs_writedata, avs_readdata, q;
  logic [NCH-1:0] tbl_load;
  logic [NCH-1:0][NPTS-1:0] tbl_data;
  logic [NPTS-1:0] loopback, field_pwr_ok, sense_volt, sense_curr, load_sw1, load_sw2;
  logic [NPTS-1:0] point_led, fault_report, seen, seen2;
  int failures, n_compared, n;
  tvd_top #(.GLITCH_LEN(8), .AC_HALF_LEN(6), .GAP_LEN(4), .SETTLE_LEN(4)) dut_u (
    .clk(clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .tbl_load(tbl_load),
    .tbl_data(tbl_data), .loopback(loopback), .field_pwr_ok(field_pwr_ok),
    .sense_volt(sense_volt), .sense_curr(sense_curr), .load_sw1(load_sw1),
    .load_sw2(load_sw2), .point_led(point_led), .pass_led(pass_led), .fault_led(fault_led),
    .active_led(active_led), .field_alarm_led(field_alarm_led), .load_lost(load_lost),
    .fault_report(fault_report));
  tvd_proc_model p_u (
    .clk(clk), .load_sw1(load_sw1), .point_led(point_led), .tbl_load(tbl_load),
    .tbl_data(tbl_data),
    .loopback(loopback), .field_pwr_ok(field_pwr_ok), .sense_volt(sense_volt),
    .sense_curr(sense_curr));
  // ----------------------------------------------------------------
  // Bus access, comparison and observation
  // ----------------------------------------------------------------
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: seen %h expected %h", $time, got, exp);
    end
  endtask
  task acc(input logic w, input logic [5:0] a, input logic [31:0] d);
    @(posedge clk);
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= d;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task watch(input int cyc);
    n = 0;
    seen = '0;
    seen2 = '0;
    repeat (cyc) begin
      @(posedge clk);
      if (load_sw1 !== point_led) n++;
      seen |= point_led & ~load_sw1;
      seen2 |= load_sw1 ^ load_sw2;
    end
  endtask
  task final_report;
    $display("compared %0d, failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial begin
    repeat (30000) @(posedge clk);
    failures++;
    $display("watchdog expired at %0t", $time);
    final_report;
  end
  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    {rst, avs_read, avs_write, avs_address, avs_writedata} = {1'b1, 40'h0};
    avs_byteenable = 4'hF;
    failures = 0;
    n_compared = 0;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    acc(0, OFS_CTRL, 0);
    chk(q, CTRL_RESET);
    acc(0, 6'h3C, 0);
    chk(q, 0);
    $display("test reset done");
    p_u.send({32'hAAAAAAAA, 32'hCCCCCCCC, 32'hF0F0F0F0});
    acc(1, OFS_CTRL, 32'h33);
    repeat (3) @(posedge clk);
    chk(load_sw1, 32'hE8E8E8E8);
    chk(point_led, 32'hE8E8E8E8);
    chk(32'(active_led), 1);
    p_u.send({32'h0, 32'hCCCCCCCC, 32'hF0F0F0F0});
    repeat (3) @(posedge clk);
    chk(load_sw1, 32'hC0C0C0C0);
    acc(0, OFS_VOTED, 0);
    chk(q, 32'hC0C0C0C0);
    p_u.lb_flip <= 32'h100;
    acc(0, OFS_LOOPBACK, 0);
    chk(q, 32'hC0C0C1C0);
    repeat (9) @(posedge clk);
    p_u.lb_flip <= '0;
    chk(fault_report, 32'h100);
    chk(32'(fault_led), 1);
    chk(32'(pass_led), 0);
    repeat (6) @(posedge clk);
    chk(fault_report, 32'h100);
    acc(1, OFS_DIAG_FAULT, 32'h100);
    @(posedge clk);
    chk(fault_report, 0);
    $display("test relay done");
    p_u.send({32'h0, ONES, ONES});
    acc(1, OFS_CTRL, 32'h03);
    watch(1600);
    chk(seen, ONES);
    chk(fault_report, 0);
    p_u.lb_flip <= 32'h8;
    watch(1600);
    p_u.lb_flip <= '0;
    chk(fault_report, 32'h8);
    acc(0, OFS_STATUS, 0);
    chk(q & 32'h1, 32'h1);
    acc(1, OFS_DIAG_FAULT, 32'h8);
    $display("test dc diagnostic done");
    acc(1, OFS_CTRL, 32'h01);
    repeat (3) @(posedge clk);
    watch(400);
    chk(32'(n), 0);
    p_u.send({ONES, ONES, ONES});
    repeat (3) @(posedge clk);
    chk(load_sw1, ONES);
    p_u.send('0);
    repeat (3) @(posedge clk);
    chk(load_sw1, 0);
    $display("test disable done");
    p_u.send({32'h0, ONES, ONES});
    acc(1, OFS_CTRL, 32'h13);
    p_u.lb_flip <= 32'h1;
    watch(1600);
    chk(fault_report, 32'h1);
    acc(0, OFS_STATUS, 0);
    chk(q & 32'h4, 32'h4);
    watch(400);
    chk(32'(n), 0);
    p_u.lb_flip <= '0;
    acc(1, OFS_DIAG_FAULT, 32'h1);
    acc(1, OFS_CTRL, 32'h01);
    $display("test ac diagnostic done");
    acc(1, OFS_CTRL, 32'h23);
    watch(2400);
    chk(seen2, ONES);
    acc(1, OFS_CTRL, 32'h01);
    $display("test dual done");
    p_u.send({3{32'h0000FFFF}});
    {p_u.no_pwr, p_u.open_ld} <= {32'h1, 32'h2};
    {p_u.shrt_on, p_u.shrt_off} <= {32'h10000, 32'h20000};
    acc(1, OFS_CTRL, 32'h43);
    repeat (20) @(posedge clk);
    chk(32'(load_lost), 1);
    chk(32'(field_alarm_led), 1);
    for (int i = 0; i < NSUP; i++) begin
      acc(0, OFS_SUP_BASE + 6'(4 * i), 0);
      chk(q, SUP_EXP[i]);
    end
    {p_u.no_pwr, p_u.open_ld, p_u.shrt_on, p_u.shrt_off} <= '0;
    repeat (2) @(posedge clk);
    for (int i = 0; i < NSUP; i++) acc(1, OFS_SUP_BASE + 6'(4 * i), SUP_EXP[i]);
    repeat (2) @(posedge clk);
    chk(32'(field_alarm_led), 0);
    chk(32'(load_lost), 0);
    $display("test supervised done");
    final_report;
  end
endmodule
